//--- rtl/mcfd_top.sv
// MAC control sublayer: receive steering, transmit gating, control primitives
`default_nettype none

module mcfd_top
  import mcfd_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_bypass,
  input  wire logic       i_rx_enable,
  input  wire mcfd_byte_t i_mac_rx,
  output mcfd_byte_t      o_cl_rx,
  input  wire mcfd_byte_t i_cl_tx,
  output logic            o_cl_tx_ready,
  output mcfd_byte_t      o_mac_tx,
  input  wire logic       i_mac_tx_ready,
  input  wire mcfd_disp_t i_ctl_req,
  output mcfd_disp_t      o_req_disp,
  output mcfd_disp_t      o_rx_disp,
  output logic            o_rx_drop,
  input  wire mcfd_byte_t i_fn_tx,
  output logic            o_fn_tx_ready,
  input  wire logic       i_fn_hold,
  input  wire logic       i_fn_drop,
  input  wire mcfd_ind_t  i_fn_ind,
  output mcfd_ind_t       o_ctl_ind
);

  // Receive path state
  mcfd_byte_t  dly_q [MCFD_DLY];
  mcfd_byte_t  cl_rx_q;
  mcfd_byte_t  cl_rx_d;
  mcfd_byte_t  dly_tail;
  logic        fwd;
  logic        cls_valid;
  logic        cls_ctl;

  // Transmit path state
  mcfd_tx_st_t st_q;
  mcfd_tx_st_t st_d;
  mcfd_byte_t  mac_q;
  mcfd_byte_t  mac_d;
  logic        adv;
  logic        cl_take;
  logic        fn_take;
  logic        cl_beat;
  logic        fn_beat;
  logic        fn_start;
  logic        cl_start;
  logic        cl_discard;

  // Control primitives
  mcfd_disp_t  req_q;
  mcfd_ind_t   ind_q;

  // The MAC stream has no ready: nothing here may ever push back on it
  mcfd_rx_class u_rx_class (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_rx        (i_mac_rx),
    .i_rx_enable (i_rx_enable),
    .i_bypass    (i_bypass),
    .o_fwd       (fwd),
    .o_cls_valid (cls_valid),
    .o_cls_ctl   (cls_ctl),
    .o_disp      (o_rx_disp),
    .o_drop      (o_rx_drop)
  );

  // Header delay: the verdict lands before the first octet leaves
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int k = 0; k < MCFD_DLY; k++) begin
        dly_q[k] <= MCFD_BYTE_RST;
      end
    end else begin
      dly_q[0] <= i_mac_rx;
      for (int k = 1; k < MCFD_DLY; k++) begin
        dly_q[k] <= dly_q[k-1];
      end
    end
  end

  // Data frames pass unchanged; control frames are masked out
  assign dly_tail      = dly_q[MCFD_DLY-1];
  assign cl_rx_d.valid = dly_tail.valid && fwd;
  assign cl_rx_d.sof   = dly_tail.sof;
  assign cl_rx_d.eof   = dly_tail.eof;
  assign cl_rx_d.data  = dly_tail.data;

  // Client data indication register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cl_rx_q <= MCFD_BYTE_RST;
    end else begin
      cl_rx_q <= cl_rx_d;
    end
  end

  assign o_cl_rx = cl_rx_q;

  // Transmit handshake decode; the MAC's own ready is obeyed as-is
  assign adv           = !mac_q.valid || i_mac_tx_ready;
  assign cl_take       = ((st_q == MCFD_TX_CLIENT) && adv) || (st_q == MCFD_TX_DROP);
  assign fn_take       = (st_q == MCFD_TX_FUNC) && adv;
  assign o_cl_tx_ready = cl_take;
  assign o_fn_tx_ready = fn_take;
  assign cl_beat       = i_cl_tx.valid && cl_take;
  assign fn_beat       = i_fn_tx.valid && fn_take;

  // Frame start decode; handler frames win a tie at a boundary
  assign fn_start   = i_fn_tx.valid && i_fn_tx.sof && !i_bypass;
  assign cl_start   = i_cl_tx.valid && i_cl_tx.sof && (i_bypass || !i_fn_hold);
  assign cl_discard = i_fn_drop && !i_bypass;

  // Gating acts only between frames, so a frame is never cut in two
  always_comb begin
    st_d = st_q;
    case (st_q)
      MCFD_TX_IDLE: begin
        if (fn_start) begin
          st_d = MCFD_TX_FUNC;
        end else if (cl_start) begin
          st_d = cl_discard ? MCFD_TX_DROP : MCFD_TX_CLIENT;
        end
      end
      MCFD_TX_CLIENT: begin
        if (cl_beat && i_cl_tx.eof) begin
          st_d = MCFD_TX_IDLE;
        end
      end
      MCFD_TX_DROP: begin
        if (cl_beat && i_cl_tx.eof) begin
          st_d = MCFD_TX_IDLE;
        end
      end
      MCFD_TX_FUNC: begin
        if (fn_beat && i_fn_tx.eof) begin
          st_d = MCFD_TX_IDLE;
        end
      end
      default: begin
        st_d = MCFD_TX_IDLE;
      end
    endcase
  end

  // Next MAC octet: client data, handler frame, or an empty slot
  assign mac_d = !adv ? mac_q :
                 (cl_beat && (st_q == MCFD_TX_CLIENT)) ? i_cl_tx :
                 fn_beat ? i_fn_tx : MCFD_BYTE_RST;

  // Transmit state and output register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_q  <= MCFD_TX_RST;
      mac_q <= MCFD_BYTE_RST;
    end else begin
      st_q  <= st_d;
      mac_q <= mac_d;
    end
  end

  assign o_mac_tx = mac_q;

  // Client control requests launch a handler; ignored when bypassed
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      req_q <= MCFD_DISP_RST;
    end else begin
      req_q.valid  <= i_ctl_req.valid && !i_bypass;
      req_q.opcode <= i_ctl_req.opcode;
      req_q.param  <= i_ctl_req.param;
    end
  end

  assign o_req_disp = req_q;

  // Handler state reaches the client as control indications
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ind_q <= MCFD_IND_RST;
    end else begin
      ind_q.valid  <= i_fn_ind.valid && !i_bypass;
      ind_q.opcode <= i_fn_ind.opcode;
      ind_q.state  <= i_fn_ind.state;
    end
  end

  assign o_ctl_ind = ind_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  fwd_transparent_a: assert property (
    o_cl_rx.valid |-> (o_cl_rx.data == $past(i_mac_rx.data, 15)) &&
                      (o_cl_rx.sof == $past(i_mac_rx.sof, 15)))
    else $error("forwarded octet differs from received octet");

  ctl_sunk_a: assert property (
    cls_valid && cls_ctl |-> ##2 (!o_cl_rx.valid) [*8])
    else $error("control frame leaked to the client");

  data_reaches_a: assert property (
    cls_valid && !cls_ctl |-> ##2 o_cl_rx.valid)
    else $error("data frame not forwarded");

  mac_stable_a: assert property (
    o_mac_tx.valid && !i_mac_tx_ready |=> $stable(o_mac_tx))
    else $error("transmit octet changed while stalled");

  hold_gate_a: assert property (
    (st_q == MCFD_TX_IDLE) && i_fn_hold && !i_bypass |=> (st_q != MCFD_TX_CLIENT))
    else $error("client frame started while held");

  drop_silent_a: assert property (
    (st_q == MCFD_TX_DROP) && !o_mac_tx.valid |=> !o_mac_tx.valid)
    else $error("discarded client frame reached the MAC");

  req_disp_a: assert property (
    i_ctl_req.valid && !i_bypass |=> o_req_disp.valid &&
      (o_req_disp.opcode == $past(i_ctl_req.opcode)))
    else $error("control request not dispatched");

  ind_pass_a: assert property (
    i_fn_ind.valid && !i_bypass |=> o_ctl_ind.valid &&
      (o_ctl_ind.state == $past(i_fn_ind.state)))
    else $error("state indication lost");

  bypass_plain_a: assert property (
    i_bypass |=> !o_rx_disp.valid && !o_req_disp.valid && !o_ctl_ind.valid)
    else $error("control processing active in bypass");

  // Transmit frame selection and gating
  fn_first_a: assert property (
    (st_q == MCFD_TX_IDLE) && fn_start |=> (st_q == MCFD_TX_FUNC))
    else $error("handler frame not chosen first");

  cl_entry_a: assert property (
    (st_q == MCFD_TX_IDLE) && !fn_start && cl_start && !cl_discard |=>
      (st_q == MCFD_TX_CLIENT))
    else $error("client frame not started");

  drop_entry_a: assert property (
    (st_q == MCFD_TX_IDLE) && !fn_start && cl_start && cl_discard |=>
      (st_q == MCFD_TX_DROP))
    else $error("client frame not discarded");

  idle_closed_a: assert property (
    (st_q == MCFD_TX_IDLE) |-> !o_cl_tx_ready && !o_fn_tx_ready)
    else $error("octet accepted between frames");

  drop_ready_a: assert property (
    (st_q == MCFD_TX_DROP) |-> o_cl_tx_ready)
    else $error("discarded frame not swallowed");

  stall_block_a: assert property (
    o_mac_tx.valid && !i_mac_tx_ready && (st_q != MCFD_TX_DROP) |->
      !o_cl_tx_ready && !o_fn_tx_ready)
    else $error("octet accepted while the MAC stalls");

  cl_end_a: assert property (
    cl_beat && i_cl_tx.eof |=> (st_q == MCFD_TX_IDLE))
    else $error("client frame end missed");

  fn_end_a: assert property (
    fn_beat && i_fn_tx.eof |=> (st_q == MCFD_TX_IDLE))
    else $error("handler frame end missed");

  bypass_tx_a: assert property (
    i_bypass && (st_q == MCFD_TX_IDLE) |=>
      (st_q != MCFD_TX_FUNC) && (st_q != MCFD_TX_DROP))
    else $error("transmit gating active in bypass");

  // Octet copies and primitive payloads
  cl_copy_a: assert property (
    cl_beat && (st_q == MCFD_TX_CLIENT) |=> (o_mac_tx == $past(i_cl_tx)))
    else $error("client octet altered on the way to the MAC");

  fn_copy_a: assert property (
    fn_beat |=> (o_mac_tx == $past(i_fn_tx)))
    else $error("handler octet altered on the way to the MAC");

  ctl_mask_a: assert property (
    dly_tail.valid && !fwd |=> !o_cl_rx.valid)
    else $error("consumed octet shown to the client");

  fwd_eof_a: assert property (
    o_cl_rx.valid |-> (o_cl_rx.eof == $past(i_mac_rx.eof, 15)))
    else $error("forwarded frame end misplaced");

  req_param_a: assert property (
    i_ctl_req.valid && !i_bypass |=>
      (o_req_disp.param == $past(i_ctl_req.param)))
    else $error("control request parameter lost");

  req_quiet_a: assert property (
    !i_ctl_req.valid |=> !o_req_disp.valid)
    else $error("dispatch without a control request");

  ind_code_a: assert property (
    i_fn_ind.valid && !i_bypass |=>
      (o_ctl_ind.opcode == $past(i_fn_ind.opcode)))
    else $error("indication opcode lost");

  ind_quiet_a: assert property (
    !i_fn_ind.valid |=> !o_ctl_ind.valid)
    else $error("indication without a handler report");

endmodule : mcfd_top

`default_nettype wire

//--- inc/mcfd_pkg.sv
// Constants and carrier types for the MAC control frame dispatcher
// Behaviour
// - The block sits between the MAC and its client and maps client primitives onto MAC calls.
// - The block offers a control request input and a control indication output to the client.
// - Each client control request is interpreted and may start transmits or internal actions.
// - A client data request is sent at once, held, dropped or altered as the control state says; the code never alters one.
// - A received data frame goes to the client unchanged as a data indication.
// - A received control frame is handled inside and may change state or raise indications.
// - Control frames are always consumed and never reach the client as data; with i_bypass set the code forwards them to the client.
// - Control and client frames are told apart only by the Length/Type field value.
// - Control indications carry the current internal state values to the client.
// - The block needs no change to the MAC and looks to it like an ordinary client.
// - Without the control layer the client links straight to the MAC with no processing.
// - Length/Type 88-08 marks a control frame and every other value marks a data frame.
// - The opcode is the first two payload octets after the Length/Type field.
// - A control frame with an unsupported opcode is dropped and the drop is reported.
// - An over-long supported control frame is cut to the minimum size and then acted on.
`default_nettype none

package mcfd_pkg;

  // Frame layout, octet indices counted from the first destination octet
  localparam logic [15:0] MCFD_CTL_TYPE  = 16'h8808;
  localparam logic [6:0]  MCFD_IDX_LT_HI = 7'h0C;
  localparam logic [6:0]  MCFD_IDX_LT_LO = 7'h0D;
  localparam logic [6:0]  MCFD_IDX_OP_HI = 7'h0E;
  localparam logic [6:0]  MCFD_IDX_OP_LO = 7'h0F;
  localparam logic [6:0]  MCFD_IDX_PAR_F = 7'h10;
  localparam logic [6:0]  MCFD_IDX_PAR_L = 7'h13;
  localparam logic [6:0]  MCFD_IDX_MAX   = 7'h7F;

  // Minimum frame counts the FCS, which the MAC strips before handing over
  localparam int          MCFD_MIN_FRAME = 64;
  localparam int          MCFD_FCS_LEN   = 4;
  localparam logic [6:0]  MCFD_CTL_LAST  = 7'(MCFD_MIN_FRAME - MCFD_FCS_LEN - 1);

  // Receive delay covers the header up to the Length/Type field
  localparam int          MCFD_DLY       = 14;

  // Opcodes served by the attached handlers; plain defaults
  localparam logic [15:0] MCFD_OP_SUPP_A = 16'h0001;
  localparam logic [15:0] MCFD_OP_SUPP_B = 16'h0002;

  // One octet of a frame stream
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } mcfd_byte_t;

  // Control request or dispatch to an opcode handler
  typedef struct packed {
    logic        valid;
    logic [15:0] opcode;
    logic [31:0] param;
  } mcfd_disp_t;

  // State indication toward the client
  typedef struct packed {
    logic        valid;
    logic [15:0] opcode;
    logic [15:0] state;
  } mcfd_ind_t;

  typedef enum logic [1:0] {
    MCFD_TX_IDLE   = 2'b00,
    MCFD_TX_CLIENT = 2'b01,
    MCFD_TX_DROP   = 2'b11,
    MCFD_TX_FUNC   = 2'b10
  } mcfd_tx_st_t;

  // Values after reset
  localparam mcfd_byte_t  MCFD_BYTE_RST = '0;
  localparam mcfd_disp_t  MCFD_DISP_RST = '0;
  localparam mcfd_ind_t   MCFD_IND_RST  = '0;
  localparam mcfd_tx_st_t MCFD_TX_RST   = MCFD_TX_IDLE;

  // Saturating octet index, so long frames never wrap into the header
  function automatic logic [6:0] mcfd_idx_inc(input logic [6:0] idx);
    mcfd_idx_inc = (idx == MCFD_IDX_MAX) ? idx : idx + 7'h01;
  endfunction : mcfd_idx_inc

  function automatic logic mcfd_op_supported(input logic [15:0] op);
    mcfd_op_supported = (op == MCFD_OP_SUPP_A) || (op == MCFD_OP_SUPP_B);
  endfunction : mcfd_op_supported

endpackage : mcfd_pkg

`default_nettype wire

//--- rtl/mcfd_rx_class.sv
// Receive classifier: Length/Type check, opcode capture and dispatch
`default_nettype none

module mcfd_rx_class
  import mcfd_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire mcfd_byte_t i_rx,
  input  wire logic       i_rx_enable,
  input  wire logic       i_bypass,
  output logic            o_fwd,
  output logic            o_cls_valid,
  output logic            o_cls_ctl,
  output mcfd_disp_t      o_disp,
  output logic            o_drop
);

  logic [6:0]  idx_q;
  logic [7:0]  lt_hi_q;
  logic        ctl_q;
  logic        en_q;
  logic        fwd_q;
  logic [15:0] op_q;
  logic [31:0] par_q;
  mcfd_disp_t  disp_q;
  logic        drop_q;

  logic [6:0]  cur_idx;
  logic        frame_en;
  logic        at_lt;
  logic        ctl_now;
  logic        ctl_frame;
  logic        at_eof;
  logic        long_ok;
  logic        op_ok;
  logic        in_par;

  // Index decode of the octet on the input this cycle
  assign cur_idx   = i_rx.sof ? 7'h00 : idx_q;
  assign frame_en  = i_rx.sof ? i_rx_enable : en_q;
  assign at_lt     = i_rx.valid && (cur_idx == MCFD_IDX_LT_LO);
  assign ctl_now   = ({lt_hi_q, i_rx.data} == MCFD_CTL_TYPE) && !i_bypass;
  assign ctl_frame = at_lt ? ctl_now : (ctl_q && !i_rx.sof); // No stale verdict
  assign at_eof    = i_rx.valid && i_rx.eof && frame_en;
  // Octets past the minimum are ignored, which truncates long frames
  assign long_ok   = cur_idx >= MCFD_CTL_LAST;
  assign op_ok     = mcfd_op_supported(op_q);
  assign in_par    = (cur_idx >= MCFD_IDX_PAR_F) && (cur_idx <= MCFD_IDX_PAR_L);

  assign o_cls_valid = at_lt && frame_en;
  assign o_cls_ctl   = ctl_now;
  assign o_fwd       = fwd_q;
  assign o_disp      = disp_q;
  assign o_drop      = drop_q;

  // Per-frame parse state; frames shorter than the header count as data
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      idx_q   <= 7'h00;
      lt_hi_q <= 8'h00;
      ctl_q   <= 1'b0;
      en_q    <= 1'b0;
      fwd_q   <= 1'b0;
      op_q    <= 16'h0000;
      par_q   <= 32'h0000_0000;
    end else if (i_rx.valid) begin
      idx_q <= mcfd_idx_inc(cur_idx);
      en_q  <= frame_en;
      if (i_rx.sof) begin
        ctl_q <= 1'b0;
      end
      if (cur_idx == MCFD_IDX_LT_HI) begin
        lt_hi_q <= i_rx.data;
      end
      if (at_lt) begin
        ctl_q <= ctl_now;
        fwd_q <= frame_en && !ctl_now;
      end else if (i_rx.eof && (cur_idx < MCFD_IDX_LT_LO)) begin
        fwd_q <= frame_en;
      end
      if (cur_idx == MCFD_IDX_OP_HI) begin
        op_q[15:8] <= i_rx.data;
      end
      if (cur_idx == MCFD_IDX_OP_LO) begin
        op_q[7:0] <= i_rx.data;
      end
      if (in_par) begin
        par_q <= {par_q[23:0], i_rx.data};
      end
    end
  end

  // Verdict at end of frame: launch a handler or report a drop
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      disp_q <= MCFD_DISP_RST;
      drop_q <= 1'b0;
    end else begin
      disp_q.valid  <= at_eof && ctl_frame && long_ok && op_ok && !i_bypass;
      disp_q.opcode <= op_q;
      disp_q.param  <= par_q;
      drop_q        <= at_eof && ctl_frame && !(long_ok && op_ok);
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  cls_steers_fwd_a: assert property (
    o_cls_valid |=> (o_fwd == !$past(o_cls_ctl)))
    else $error("classification did not steer forwarding");

  drop_excl_a: assert property (
    o_drop |-> !o_disp.valid)
    else $error("dropped frame was also dispatched");

  disp_supported_a: assert property (
    o_disp.valid |-> mcfd_op_supported(o_disp.opcode))
    else $error("unsupported opcode dispatched");

  disp_min_len_a: assert property (
    o_disp.valid |-> ($past(cur_idx) >= MCFD_CTL_LAST))
    else $error("short control frame dispatched");

endmodule : mcfd_rx_class

`default_nettype wire

//--- verification/mcfd_mac_model.sv
// MAC-side partner: receive frame source and stalling transmit sink
`default_nettype none

module mcfd_mac_model
  import mcfd_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_slow,
  input  wire mcfd_byte_t i_tx,
  output var mcfd_byte_t  o_rx,
  output var logic        o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  int         cyc = 0;
  int         t_sof;
  int         t_eof;
  logic [1:0] pace = 2'h0;
  logic [7:0] got[$];

  initial begin
    o_rx = '0;
    o_tx_ready = 1'b0;
  end

  // Cycle stamp shared with the bench for latency checks
  always @(posedge i_ref_clk) cyc <= cyc + 1;

  // Sink: slow mode takes one octet in four, like a busy MAC
  always @(negedge i_ref_clk) begin
    pace = pace + 2'h1;
    o_tx_ready = !i_slow || (pace == 2'h0);
    #20;
    if (i_tx.valid && o_tx_ready) got.push_back(i_tx.data);
  end

  // Every frame goes up whole; the idle line then shows the last octet inverted for one cycle, then the last octet again
  task automatic send(input logic [7:0] f[$]);
    logic [7:0] last;
    last = 8'h00;
    foreach (f[i]) begin
      @(negedge i_ref_clk);
      o_rx = '{1'b1, (i == 0), (i == f.size() - 1), f[i]};
      if (i == 0) t_sof = cyc;
      t_eof = cyc;
      last = f[i];
    end
    repeat (2) begin
      @(negedge i_ref_clk);
      last = ~last;
      o_rx = '{1'b0, 1'b0, 1'b0, last};
    end
  endtask : send

endmodule : mcfd_mac_model

`default_nettype wire

//--- verification/test_mac_control_frame_dispatch.sv
// Self-checking bench for the MAC control frame dispatcher
`default_nettype none

module test_mac_control_frame_dispatch
  import mcfd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LIMIT = 20000; // Run needs about two thousand cycles

  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_bypass = 1'b0;
  logic        i_rx_enable = 1'b1;
  logic        slow = 1'b0;
  logic        i_fn_hold = 1'b0;
  logic        i_fn_drop = 1'b0;
  mcfd_byte_t  i_cl_tx = '0;
  mcfd_byte_t  i_fn_tx = '0;
  mcfd_disp_t  i_ctl_req = '0;
  mcfd_ind_t   i_fn_ind = '0;
  mcfd_byte_t  mac_rx, mac_tx, cl_rx;
  mcfd_disp_t  req_disp, rx_disp, disp_seen, rq;
  mcfd_ind_t   ctl_ind, ind;
  logic        mac_rdy, cl_rdy, fn_rdy, rx_drop;
  logic [31:0] seed = 32'h30453A4B;
  logic [15:0] lt;
  logic [7:0]  fr[$];
  logic [7:0]  rxq[$];
  int          ndisp, ndrop, len;
  int          mismatches = 0;
  int          cmp_count = 0;

  always #25 i_ref_clk = ~i_ref_clk;

  mcfd_top dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bypass(i_bypass),
    .i_rx_enable(i_rx_enable), .i_mac_rx(mac_rx), .o_cl_rx(cl_rx), .i_cl_tx(i_cl_tx),
    .o_cl_tx_ready(cl_rdy), .o_mac_tx(mac_tx), .i_mac_tx_ready(mac_rdy),
    .i_ctl_req(i_ctl_req), .o_req_disp(req_disp), .o_rx_disp(rx_disp),
    .o_rx_drop(rx_drop), .i_fn_tx(i_fn_tx), .o_fn_tx_ready(fn_rdy),
    .i_fn_hold(i_fn_hold), .i_fn_drop(i_fn_drop), .i_fn_ind(i_fn_ind),
    .o_ctl_ind(ctl_ind));

  mcfd_mac_model mdl_u (.i_ref_clk(i_ref_clk), .i_slow(slow), .i_tx(mac_tx),
    .o_rx(mac_rx), .o_tx_ready(mac_rdy));

  // Xorshift source, fixed seed so every run repeats
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("counts: %0d compared, %0d wrong", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // Pulses stand one cycle, so watch every falling edge
  always @(negedge i_ref_clk) begin
    if (cl_rx.valid) rxq.push_back(cl_rx.data);
    if (cl_rx.valid && cl_rx.sof) chk(mdl_u.cyc, mdl_u.t_sof + 15);
    if (rx_disp.valid) begin
      ndisp++;
      disp_seen = rx_disp;
      chk(mdl_u.cyc, mdl_u.t_eof + 1);
    end
    if (rx_drop) ndrop++;
    if (mdl_u.cyc > LIMIT) begin
      mismatches++;
      stop_test();
    end
  end

  // One received frame; wait out the delay line before judging
  task automatic rx_case(input int n, input logic [15:0] t, input logic [15:0] op,
                         input logic fwd, input logic dsp, input logic drp);
    fr.delete();
    rxq.delete();
    ndisp = 0;
    ndrop = 0;
    for (int i = 0; i < n; i++) fr.push_back(8'(rnd()));
    if (n > 13) {fr[12], fr[13]} = t;
    if (n > 15) {fr[14], fr[15]} = op;
    mdl_u.send(fr);
    repeat (20) @(negedge i_ref_clk);
    chk(rxq.size(), fwd ? n : 0);
    if (fwd) foreach (rxq[i]) chk(rxq[i], fr[i]);
    chk(ndisp, dsp);
    chk(ndrop, drp);
    if (dsp) chk(disp_seen, {1'b1, op, fr[16], fr[17], fr[18], fr[19]});
  endtask : rx_case

  // Streams a frame on client or handler port; octet advances only when taken
  task automatic tx_case(input logic fn, input int n, input logic gone);
    int i;
    int w;
    mcfd_byte_t cur;
    i = 0;
    w = 0;
    fr.delete();
    mdl_u.got.delete();
    for (int k = 0; k < n; k++) fr.push_back(8'(rnd()));
    while (i < n && w < 500) begin
      @(negedge i_ref_clk);
      cur = '{1'b1, (i == 0), (i == n - 1), fr[i]};
      if (fn) i_fn_tx = cur;
      else i_cl_tx = cur;
      #20;
      if (fn ? fn_rdy : cl_rdy) i++;
      w++;
    end
    @(negedge i_ref_clk);
    i_fn_tx = '0;
    i_cl_tx = '0;
    repeat (10) @(negedge i_ref_clk);
    chk(i, n);
    chk(mdl_u.got.size(), gone ? 0 : n);
    if (!gone) foreach (mdl_u.got[k]) chk(mdl_u.got[k], fr[k]);
    $display("test tx done");
  endtask : tx_case

  initial begin
    repeat (6) @(negedge i_ref_clk);
    i_rst = 1'b0;
    @(negedge i_ref_clk);
    chk({cl_rx.valid, rx_disp.valid, rx_drop, mac_tx.valid, cl_rdy}, 5'h00);
    // Random data frames, short ones included
    for (int k = 0; k < 10; k++) begin
      len = 8 + int'(rnd() % 70);
      lt = 16'(rnd());
      if (lt == MCFD_CTL_TYPE) lt = 16'h0800;
      rx_case(len, lt, 16'h0000, 1'b1, 1'b0, 1'b0);
    end
    $display("test rx data done");
    rx_case(60, MCFD_CTL_TYPE, MCFD_OP_SUPP_A, 1'b0, 1'b1, 1'b0);
    rx_case(60, MCFD_CTL_TYPE, MCFD_OP_SUPP_B, 1'b0, 1'b1, 1'b0);
    rx_case(90, MCFD_CTL_TYPE, MCFD_OP_SUPP_A, 1'b0, 1'b1, 1'b0);
    rx_case(60, MCFD_CTL_TYPE, 16'h0003, 1'b0, 1'b0, 1'b1);
    rx_case(59, MCFD_CTL_TYPE, MCFD_OP_SUPP_B, 1'b0, 1'b0, 1'b1);
    rx_case(60, 16'h8809, MCFD_OP_SUPP_A, 1'b1, 1'b0, 1'b0);
    i_bypass = 1'b1;
    rx_case(60, MCFD_CTL_TYPE, MCFD_OP_SUPP_A, 1'b1, 1'b0, 1'b0);
    i_ctl_req = '{1'b1, MCFD_OP_SUPP_A, 32'h0000_00A5};
    i_fn_ind = '{1'b1, MCFD_OP_SUPP_B, 16'h005A};
    @(negedge i_ref_clk);
    i_ctl_req = '0;
    i_fn_ind = '0;
    chk({req_disp.valid, ctl_ind.valid}, 2'h0);
    i_bypass = 1'b0;
    i_rx_enable = 1'b0;
    rx_case(30, 16'h0800, 16'h0000, 1'b0, 1'b0, 1'b0);
    i_rx_enable = 1'b1;
    $display("test rx control done");
    slow = 1'b1;
    tx_case(1'b0, 40, 1'b0);
    tx_case(1'b1, 30, 1'b0);
    slow = 1'b0;
    i_fn_drop = 1'b1;
    tx_case(1'b0, 25, 1'b1);
    i_fn_drop = 1'b0;
    i_fn_hold = 1'b1;
    i_cl_tx = '{1'b1, 1'b1, 1'b0, 8'h5A};
    repeat (8) begin
      @(negedge i_ref_clk);
      chk(cl_rdy, 1'b0);
    end
    i_cl_tx = '0;
    @(negedge i_ref_clk);
    i_fn_hold = 1'b0;
    tx_case(1'b0, 20, 1'b0);
    // Back-to-back control requests and handler indications
    for (int k = 0; k <= 4; k++) begin
      @(negedge i_ref_clk);
      if (k > 0) chk(req_disp, rq);
      if (k > 0) chk(ctl_ind, ind);
      rq = (k < 4) ? {1'b1, 16'(rnd()), rnd()} : '0;
      ind = (k < 4) ? {1'b1, 16'(rnd()), 16'(rnd())} : '0;
      i_ctl_req = rq;
      i_fn_ind = ind;
    end
    $display("test control primitives done");
    stop_test();
  end

endmodule : test_mac_control_frame_dispatch

`default_nettype wire
